// ===== pmrc_regs.svh
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH

// Channel count and the channels that stay usable during reset and limp home.
`define PMRC_NUM_CH           4
`define PMRC_RESTRICT_CH_MASK 4'h7

// Sense selector code that parks the device in stand-by.
`define PMRC_SEL_STANDBY      3'h7

// Clock rate and the timing figures in their own units.
`define PMRC_CLK_MHZ          250
`define PMRC_LH_ACK_MIN_US    5
`define PMRC_WU_PO_MAX_US     200
`define PMRC_WU_STCH_MAX_US   200

// Cycle counts derived from the figures above.
`define PMRC_LH_ACK_CYCLES    (`PMRC_LH_ACK_MIN_US * `PMRC_CLK_MHZ)
`define PMRC_WU_PO_CYCLES     (`PMRC_WU_PO_MAX_US * `PMRC_CLK_MHZ)
`define PMRC_WU_STCH_CYCLES   (`PMRC_WU_STCH_MAX_US * `PMRC_CLK_MHZ)

`endif

// ===== pmrc_pkg.sv
package pmrc_pkg;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_WAKE    = 2'h1,
    ST_NORMAL  = 2'h3,
    ST_LIMP    = 2'h2
  } mode_t;

  typedef logic [3:0] ch_vec_t;

endpackage : pmrc_pkg

// ===== power_mode_reset_control.sv
`timescale 1ns/1ps
`include "pmrc_regs.svh"
module power_mode_reset_control #(
  parameter int unsigned WU_PO_CYCLES   = `PMRC_WU_PO_CYCLES,
  parameter int unsigned WU_STCH_CYCLES = `PMRC_WU_STCH_CYCLES
) (
  input  wire logic             i_sys_clk,                 // Logic clock.
  input  wire logic             i_rst,                     // Async reset, active high.
  input  wire logic             i_logic_supply_ok,         // Logic supply above threshold.
  input  wire logic             i_switch_supply_ok,        // Power-switch supply present.
  input  wire logic             i_fallback_input,          // Limp home request pin.
  input  wire pmrc_pkg::ch_vec_t i_parallel_channel_inputs, // Parallel channel pins.
  input  wire logic [2:0]       i_sense_selector,          // Sense selector register field.
  input  wire logic             i_pwm_start_bit,           // PWM start register bit.
  input  wire logic             i_soft_reset_bit,          // Soft reset bit written as 1.
  input  wire pmrc_pkg::ch_vec_t i_reg_channel_on,         // Register channel-on bits.
  input  wire logic             i_frame_done,              // Serial frame completed.
  input  wire logic             i_standby_flag_clear,      // Software clears stand-by flag.
  output logic                  o_register_reset,          // Serial register reset.
  output logic                  o_serial_enable,           // Serial interface active.
  output logic                  o_write_enable,            // Serial writes accepted.
  output logic                  o_frame_fault_flag,        // Fault flag for next frame.
  output logic                  o_standby_flag,            // Sticky stand-by status.
  output logic                  o_clear_error_latches,     // Clear all error latches.
  output pmrc_pkg::ch_vec_t     o_error_latch_clear,       // Per-channel latch clear pulse.
  output pmrc_pkg::ch_vec_t     o_load_switches,           // Power stage on commands.
  output pmrc_pkg::mode_t       o_mode,                    // Operating mode.
  output logic                  o_limp_home,               // Limp home status bit.
  output logic                  o_wake_busy,               // Host must not access yet.
  output logic                  o_input_map_enable,        // Input-assigned mapping allowed.
  output logic                  o_diag_enable,             // Diagnosis available.
  output logic                  o_sense_enable,            // Current sensing available.
  output logic                  o_protection_enable        // Over-temperature protection on.
);
  import pmrc_pkg::*;

  localparam int unsigned LH_ACK_CYCLES = `PMRC_LH_ACK_CYCLES;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic    fb_meta;
  logic    fb_sync;
  ch_vec_t in_meta;
  ch_vec_t in_sync;
  ch_vec_t in_prev;
  logic    supply_prev;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fb_meta     <= 1'b0;
      fb_sync     <= 1'b0;
      in_meta     <= 4'h0;
      in_sync     <= 4'h0;
      in_prev     <= 4'h0;
      supply_prev <= 1'b0;
    end else begin
      fb_meta     <= i_fallback_input;
      fb_sync     <= fb_meta;
      in_meta     <= i_parallel_channel_inputs;
      in_sync     <= in_meta;
      in_prev     <= in_sync;
      supply_prev <= i_logic_supply_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Limp home qualification.

  logic [11:0] lh_cnt;
  logic        lh_qual;

  // The shortest permitted time is used so the device reacts well inside the window.
  assign lh_qual = fb_sync && (lh_cnt == 12'(LH_ACK_CYCLES));

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lh_cnt <= 12'h000;
    end else if (!fb_sync) begin
      lh_cnt <= 12'h000;
    end else if (lh_cnt != 12'(LH_ACK_CYCLES)) begin
      lh_cnt <= lh_cnt + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode state machine.

  mode_t       state;
  mode_t       next_state;
  logic [16:0] wake_cnt;
  logic        standby_cond;
  logic        wake_req;
  logic        limp_entry;

  // Without logic supply the selector and PWM bit sit at reset values anyway.
  assign standby_cond = (!i_logic_supply_ok ||
                         (i_sense_selector == `PMRC_SEL_STANDBY && !i_pwm_start_bit)) &&
                        (in_sync == 4'h0) && !fb_sync;
  assign wake_req     = i_logic_supply_ok &&
                        (i_sense_selector != `PMRC_SEL_STANDBY || i_pwm_start_bit);
  assign limp_entry   = lh_qual && (state != ST_LIMP) && !(state == ST_WAKE && o_limp_home);

  always_comb begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (lh_qual) begin
          next_state = ST_WAKE;
        end else if (wake_req) begin
          next_state = ST_WAKE;
        end else if (in_sync != 4'h0) begin
          next_state = ST_NORMAL;
        end
      end
      ST_WAKE: begin
        if (wake_cnt <= 17'h00001) begin
          next_state = o_limp_home ? ST_LIMP : ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (lh_qual) begin
          next_state = ST_LIMP;
        end else if (standby_cond) begin
          next_state = ST_STANDBY;
        end
      end
      ST_LIMP: begin
        if (!fb_sync) begin
          next_state = standby_cond ? ST_STANDBY : ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= ST_STANDBY;
    end else begin
      o_mode <= next_state;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_limp_home <= 1'b0;
    end else if (!fb_sync) begin
      o_limp_home <= 1'b0;
    end else if (lh_qual) begin
      o_limp_home <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on wake-up timer; also gates host access after supply start-up.

  logic wake_start;

  assign wake_start = (state == ST_STANDBY && next_state == ST_WAKE) ||
                      (i_logic_supply_ok && !supply_prev);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_cnt <= 17'h00000;
    end else if (wake_start) begin
      wake_cnt <= 17'(WU_PO_CYCLES);
    end else if (wake_cnt != 17'h00000) begin
      wake_cnt <= wake_cnt - 17'h00001;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wake_busy <= 1'b1;
    end else begin
      o_wake_busy <= !i_logic_supply_ok || wake_start ||
                     (wake_cnt > 17'h00001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset generation.

  logic reset_hold;

  // Stand-by entry is deliberately absent here, so programmed settings survive it.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_register_reset <= 1'b1;
    end else begin
      o_register_reset <= !i_logic_supply_ok ||
                          i_soft_reset_bit ||
                          (limp_entry && i_switch_supply_ok);
    end
  end

  assign reset_hold = o_register_reset || !i_logic_supply_ok || (state == ST_LIMP);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_fault_flag <= 1'b1;
    end else if (o_register_reset) begin
      o_frame_fault_flag <= 1'b1;
    end else if (i_frame_done) begin
      o_frame_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_enable <= 1'b0;
      o_write_enable  <= 1'b0;
    end else begin
      o_serial_enable <= i_logic_supply_ok;
      o_write_enable  <= i_logic_supply_ok && !o_limp_home && !lh_qual &&
                         !o_register_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stand-by status and error latch clearing.

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_standby_flag <= 1'b0;
    end else if (state != ST_STANDBY && next_state == ST_STANDBY) begin
      o_standby_flag <= 1'b1;
    end else if (i_standby_flag_clear) begin
      o_standby_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clear_error_latches <= 1'b1;
    end else begin
      o_clear_error_latches <= (next_state == ST_STANDBY) ||
                               o_register_reset;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_error_latch_clear <= 4'h0;
    end else if (state == ST_LIMP) begin
      o_error_latch_clear <= in_sync & ~in_prev & `PMRC_RESTRICT_CH_MASK;
    end else begin
      o_error_latch_clear <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel control.

  ch_vec_t     pin_req;
  ch_vec_t     reg_req;
  logic [16:0] ch_cnt;

  assign pin_req = reset_hold ? (in_sync & `PMRC_RESTRICT_CH_MASK) : in_sync;
  assign reg_req = (state == ST_NORMAL && !reset_hold) ? i_reg_channel_on : 4'h0;

  // The extra delay only applies when nothing was on, so a running channel never glitches.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ch_cnt <= 17'h00000;
    end else if (pin_req == 4'h0) begin
      ch_cnt <= 17'h00000;
    end else if (state == ST_STANDBY && o_load_switches == 4'h0 && ch_cnt == 17'h00000) begin
      ch_cnt <= 17'(WU_STCH_CYCLES);
    end else if (ch_cnt != 17'h00000) begin
      ch_cnt <= ch_cnt - 17'h00001;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_load_switches <= 4'h0;
    end else if (ch_cnt > 17'h00001) begin
      o_load_switches <= reg_req;
    end else if (state == ST_STANDBY && o_load_switches == 4'h0 && pin_req != 4'h0) begin
      o_load_switches <= 4'h0;
    end else begin
      o_load_switches <= reg_req | pin_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Diagnosis and feature availability.

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_input_map_enable  <= 1'b0;
      o_diag_enable       <= 1'b0;
      o_sense_enable      <= 1'b0;
      o_protection_enable <= 1'b0;
    end else begin
      o_input_map_enable  <= !reset_hold;
      o_diag_enable       <= i_logic_supply_ok &&
                             (state == ST_NORMAL || state == ST_LIMP);
      o_sense_enable      <= i_logic_supply_ok && state == ST_NORMAL &&
                             !o_limp_home;
      o_protection_enable <= 1'b1;
    end
  end

endmodule : power_mode_reset_control

// ===== pmrc_properties.sv
`timescale 1ns/1ps
module pmrc_properties #(
  parameter int unsigned WU_PO_CYCLES = 20
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic              i_fallback_input,
  input wire logic              i_soft_reset_bit,
  input wire logic              i_frame_done,
  input wire logic              o_register_reset,
  input wire logic              o_write_enable,
  input wire logic              o_frame_fault_flag,
  input wire logic              o_standby_flag,
  input wire logic              o_clear_error_latches,
  input wire pmrc_pkg::ch_vec_t o_load_switches,
  input wire pmrc_pkg::mode_t   o_mode,
  input wire logic              o_limp_home,
  input wire logic              o_sense_enable,
  input wire logic              o_protection_enable
);
  import pmrc_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [11:0] fb_cnt;
  logic [31:0] wake_cnt;
  // Counts raw pin high time, so the limp check sees the whole hold incl. synchroniser.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) fb_cnt <= '0;
    else if (!i_fallback_input) fb_cnt <= '0;
    else if (fb_cnt != 12'hfff) fb_cnt <= fb_cnt + 12'h1;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) wake_cnt <= '0;
    else if (o_mode != ST_WAKE) wake_cnt <= '0;
    else wake_cnt <= wake_cnt + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  soft_rst_a: assert property (i_soft_reset_bit |=> o_register_reset)
    else $error("soft reset not applied");
  fault_set_a: assert property (o_register_reset |=> o_frame_fault_flag)
    else $error("fault flag not set after reset");
  fault_clr_a: assert property (i_frame_done && !o_register_reset && !i_soft_reset_bit
    |=> !o_frame_fault_flag) else $error("fault flag not cleared by frame");
  stby_flag_a: assert property ($rose(o_mode == ST_STANDBY) |-> ##[0:1] o_standby_flag)
    else $error("standby flag not set on entry");
  clr_latch_a: assert property (o_mode == ST_STANDBY |-> ##[0:1] o_clear_error_latches)
    else $error("latches not cleared in standby");
  limp_sense_a: assert property (o_limp_home && $past(o_limp_home) |-> !o_sense_enable)
    else $error("sensing on in limp");
  limp_wr_a: assert property (o_limp_home && $past(o_limp_home) |-> !o_write_enable)
    else $error("writes accepted in limp");
  limp_ch_a: assert property (o_mode == ST_LIMP && $past(o_mode) == ST_LIMP
    |-> !o_load_switches[3]) else $error("channel 3 on in limp");
  limp_qual_a: assert property ($rose(o_limp_home) |-> fb_cnt >= 12'h4e2)
    else $error("limp entered too early");
  wake_len_a: assert property (wake_cnt <= WU_PO_CYCLES + 2)
    else $error("wake-up too long");
  prot_on_a: assert property (!$past(i_rst) |-> o_protection_enable)
    else $error("protection off after reset");
  cover property ($rose(o_limp_home));
  cover property ($rose(o_mode == ST_WAKE));
  cover property (i_soft_reset_bit ##1 o_register_reset);
endmodule : pmrc_properties

// ===== host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int unsigned TD_CYCLES = 4
) (
  input  wire logic    i_sys_clk,        // Clock.
  input  wire logic    i_reg_reset,      // Register reset.
  input  wire logic    i_wake_busy,      // Access not allowed.
  output logic [2:0]   o_sense_selector, // Selector field.
  output logic         o_pwm_start_bit,  // PWM start.
  output logic         o_soft_reset_bit, // Soft reset pulse.
  output pmrc_pkg::ch_vec_t o_reg_channel_on, // Channel-on bits.
  output logic         o_frame_done      // Frame end.
);
  import pmrc_pkg::*;
  initial begin
    o_sense_selector = 3'h7;
    o_pwm_start_bit = 1'b0;
    o_soft_reset_bit = 1'b0;
    o_reg_channel_on = 4'h0;
    o_frame_done = 1'b0;
  end
  // The register bank returns to defaults whenever the device resets it.
  always @(negedge i_sys_clk) begin
    if (i_reg_reset === 1'b1) begin
      o_sense_selector <= 3'h7;
      o_pwm_start_bit <= 1'b0;
      o_reg_channel_on <= 4'h0;
    end
  end
  task automatic write_regs(input logic [2:0] sel, input logic pwm, input ch_vec_t ch);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    while (i_wake_busy !== 1'b0 && n < 200) begin
      @(negedge i_sys_clk);
      n++;
    end
    o_sense_selector <= sel;
    o_pwm_start_bit <= pwm;
    o_reg_channel_on <= ch;
    o_frame_done <= 1'b1;
    @(negedge i_sys_clk);
    o_frame_done <= 1'b0;
  endtask : write_regs
  task automatic soft_reset();
    @(negedge i_sys_clk);
    o_soft_reset_bit <= 1'b1;
    @(negedge i_sys_clk);
    o_soft_reset_bit <= 1'b0;
    repeat (TD_CYCLES) @(negedge i_sys_clk);
  endtask : soft_reset
endmodule : host_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import pmrc_pkg::*;
  logic i_sys_clk, i_rst, i_logic_supply_ok, i_switch_supply_ok, i_fallback_input;
  logic i_soft_reset_bit, i_pwm_start_bit, i_frame_done, i_standby_flag_clear;
  logic [2:0] i_sense_selector;
  ch_vec_t i_parallel_channel_inputs, i_reg_channel_on, o_error_latch_clear, o_load_switches;
  ch_vec_t elc_seen;
  logic o_register_reset, o_serial_enable, o_write_enable, o_frame_fault_flag, o_standby_flag;
  logic o_clear_error_latches, o_limp_home, o_wake_busy, o_input_map_enable, o_diag_enable;
  logic o_sense_enable, o_protection_enable;
  mode_t o_mode;
  int mismatches, n_compared, cyc, n_rr, rr0;
  power_mode_reset_control #(.WU_PO_CYCLES(20), .WU_STCH_CYCLES(20)) u_power_mode_reset_control (
    .i_sys_clk, .i_rst, .i_logic_supply_ok, .i_switch_supply_ok, .i_fallback_input,
    .i_parallel_channel_inputs, .i_sense_selector, .i_pwm_start_bit, .i_soft_reset_bit,
    .i_reg_channel_on, .i_frame_done, .i_standby_flag_clear, .o_register_reset,
    .o_serial_enable, .o_write_enable, .o_frame_fault_flag, .o_standby_flag,
    .o_clear_error_latches, .o_error_latch_clear, .o_load_switches, .o_mode, .o_limp_home,
    .o_wake_busy, .o_input_map_enable, .o_diag_enable, .o_sense_enable, .o_protection_enable);
  host_model u_host_model (.i_sys_clk, .i_reg_reset(o_register_reset), .i_wake_busy(o_wake_busy),
    .o_sense_selector(i_sense_selector), .o_pwm_start_bit(i_pwm_start_bit),
    .o_soft_reset_bit(i_soft_reset_bit), .o_reg_channel_on(i_reg_channel_on),
    .o_frame_done(i_frame_done));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // Design outputs settle on the rising edge, so they are counted half a period later.
  always @(negedge i_sys_clk) begin
    cyc++;
    n_rr += int'(o_register_reset === 1'b1);
    elc_seen |= o_error_latch_clear;
    if (cyc == 6000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : wt
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    i_rst = 1'b1;
    i_logic_supply_ok = 1'b1;
    i_switch_supply_ok = 1'b1;
    i_fallback_input = 1'b0;
    i_parallel_channel_inputs = 4'h0;
    i_standby_flag_clear = 1'b0;
    elc_seen = 4'h0;
    wt(12);
    i_rst = 1'b0;
    wt(40);
    chk("mode", ST_STANDBY, o_mode);
    chk("stb", 4'h0, o_standby_flag);
    chk("clr", 4'h1, o_clear_error_latches);
    chk("tfault", 4'h1, o_frame_fault_flag);
    chk("ser", 4'h1, o_serial_enable);
    u_host_model.write_regs(3'h7, 1'b0, 4'h0);
    chk("tfault", 4'h0, o_frame_fault_flag);
    $display("test power-up done");
    u_host_model.write_regs(3'h3, 1'b0, 4'h0);
    chk("mode", ST_WAKE, o_mode);
    chk("busy", 4'h1, o_wake_busy);
    wt(30);
    chk("mode", ST_NORMAL, o_mode);
    chk("diag", 4'h3, {o_diag_enable, o_sense_enable});
    i_standby_flag_clear = 1'b1;
    wt(1);
    i_standby_flag_clear = 1'b0;
    wt(2);
    chk("stb", 4'h0, o_standby_flag);
    $display("test wake done");
    u_host_model.write_regs(3'h3, 1'b0, 4'h9);
    i_parallel_channel_inputs = 4'h2;
    wt(5);
    chk("load", 4'hb, o_load_switches);
    u_host_model.soft_reset();
    chk("load", 4'h2, o_load_switches);
    chk("tfault", 4'h1, o_frame_fault_flag);
    rr0 = n_rr;
    i_parallel_channel_inputs = 4'h0;
    wt(6);
    chk("mode", ST_STANDBY, o_mode);
    chk("nrr", 4'h0, 4'(n_rr - rr0));
    chk("stb", 4'h1, o_standby_flag);
    chk("prot", 4'h1, o_protection_enable);
    i_standby_flag_clear = 1'b1;
    wt(1);
    i_standby_flag_clear = 1'b0;
    wt(2);
    chk("stb", 4'h0, o_standby_flag);
    $display("test soft reset done");
    i_parallel_channel_inputs = 4'h1;
    wt(8);
    chk("load", 4'h0, o_load_switches);
    wt(25);
    chk("load", 4'h1, o_load_switches);
    i_logic_supply_ok = 1'b0;
    wt(4);
    chk("supoff", 4'h1, {o_serial_enable, o_write_enable, o_register_reset});
    i_parallel_channel_inputs = 4'h0;
    wt(6);
    chk("mode", ST_STANDBY, o_mode);
    i_logic_supply_ok = 1'b1;
    wt(4);
    chk("busy", 4'h1, o_wake_busy);
    wt(30);
    chk("busy", 4'h0, o_wake_busy);
    $display("test supply done");
    i_fallback_input = 1'b1;
    wt(1000);
    i_fallback_input = 1'b0;
    wt(10);
    chk("limp", 4'h0, o_limp_home);
    rr0 = n_rr;
    i_fallback_input = 1'b1;
    wt(1320);
    chk("limp", 4'h1, o_limp_home);
    chk("mode", ST_LIMP, o_mode);
    chk("lflags", 4'h2, {o_write_enable, o_input_map_enable, o_diag_enable, o_sense_enable});
    chk("rr", 4'h1, 4'(n_rr > rr0));
    i_parallel_channel_inputs = 4'h8;
    wt(30);
    elc_seen = 4'h0;
    i_parallel_channel_inputs = 4'ha;
    wt(30);
    chk("load", 4'h2, o_load_switches);
    chk("elc", 4'h2, elc_seen);
    i_fallback_input = 1'b0;
    wt(10);
    chk("limp", 4'h0, o_limp_home);
    $display("test limp done");
    test_done();
  end
endmodule : tb
bind power_mode_reset_control pmrc_properties #(.WU_PO_CYCLES(WU_PO_CYCLES)) u_pmrc_properties (
  .i_sys_clk, .i_rst, .i_fallback_input, .i_soft_reset_bit, .i_frame_done, .o_register_reset,
  .o_write_enable, .o_frame_fault_flag, .o_standby_flag, .o_clear_error_latches,
  .o_load_switches, .o_mode, .o_limp_home, .o_sense_enable, .o_protection_enable);
